/* rtl/ued_event_ctrl.sv */
/*
 * Event latch, interrupt gate and control-transfer data ports of the USB
 * device controller, with a plain single-cycle register port.
 * Assumes the protocol engine runs on core_clk and gives one-cycle event
 * pulses; the D+/D- levels arrive from pins and are synchronised here.
 */
`timescale 1ns/100ps
`default_nettype none

module ued_event_ctrl (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // Register port
    input wire logic [31:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    // Bus line levels from pins
    input wire logic busDp,
    input wire logic busDm,
    // Event pulses from the protocol engine
    input wire logic resumeStoppedSeen,
    input wire logic resetDoneSeen,
    input wire logic configChangeSeen,
    input wire logic cvStatusSeen,
    input wire logic cvDataInSeen,
    input wire logic cvDataOutSeen,
    input wire logic vendorReqSeen,
    input wire logic classReqSeen,
    input wire logic getStringSeen,
    input wire logic getConfigSeen,
    input wire logic getDeviceSeen,
    input wire logic busErrorSeen,
    input wire logic resumeSeen,
    input wire logic suspendSeen,
    input wire logic busResetSeen,
    // Received control-out words from the engine
    input wire logic ctrlOutLoad,
    input wire logic [1:0] ctrlOutIndex,
    input wire logic [31:0] ctrlOutData,
    // Outputs towards the engine and the CPU
    output logic [31:0] ctrlInDataWord0,
    output logic [5:0] stringDescOn,
    output logic [3:0] interfaceOn,
    output logic classDecodeOn,
    output logic vendorDecodeOn,
    output logic cvStall,
    output logic irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] status;
        logic [15:0] enable;
        logic [9:0] ifStr;
        logic [3:0][31:0] outWord;
        logic [31:0] inWord0;
        logic [1:0] decode;
        logic [1:0] lineMeta;
        logic [1:0] lineSync;
        logic [1:0] linePrev;
        logic [31:0] rdData;
        logic stall;
        logic irq;
    } ued_state_s;

    ued_state_s st;
    ued_state_s next_st;
    logic [15:0] eventSet;
    logic [15:0] clearMask;
    logic lineChanged;
    logic classDecode;
    logic vendorDecode;

    // ------------------------------------------------------------------
    // Event collection
    // ------------------------------------------------------------------

    // Pin levels compared only after the second flop
    assign lineChanged = st.lineSync != st.linePrev;
    assign classDecode = st.decode[1];
    assign vendorDecode = st.decode[0];

    // Gather engine pulses into their status positions
    always_comb begin
        eventSet = '0;
        eventSet[ued_pkg::EV_RESUME_STOPPED] = resumeStoppedSeen;
        eventSet[ued_pkg::EV_RESET_DONE] = resetDoneSeen;
        // Engine pulses this on both configure and unconfigure
        eventSet[ued_pkg::EV_CONFIG_CHANGE] = configChangeSeen;
        eventSet[ued_pkg::EV_BUS_TRANSITION] = lineChanged;
        eventSet[ued_pkg::EV_CV_STATUS] = cvStatusSeen;
        eventSet[ued_pkg::EV_CV_DATA_IN] = cvDataInSeen;
        eventSet[ued_pkg::EV_CV_DATA_OUT] = cvDataOutSeen;
        // Undecoded requests raise no event; they stall instead
        eventSet[ued_pkg::EV_VENDOR_REQ] = vendorReqSeen & vendorDecode;
        eventSet[ued_pkg::EV_CLASS_REQ] = classReqSeen & classDecode;
        eventSet[ued_pkg::EV_GET_STRING] = getStringSeen;
        eventSet[ued_pkg::EV_GET_CONFIG] = getConfigSeen;
        eventSet[ued_pkg::EV_GET_DEVICE] = getDeviceSeen;
        eventSet[ued_pkg::EV_BUS_ERROR] = busErrorSeen;
        eventSet[ued_pkg::EV_RESUME] = resumeSeen;
        eventSet[ued_pkg::EV_SUSPEND] = suspendSeen;
        eventSet[ued_pkg::EV_BUS_RESET] = busResetSeen;
    end

    // Write-one clear pattern for this cycle
    assign clearMask = (regWr && regAddr == ued_pkg::ADDR_EVENT_CLEAR)
        ? regWrData[15:0] : 16'h0000;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        // Two-flop synchroniser for the line levels
        next_st.lineMeta = {busDp, busDm};
        next_st.lineSync = st.lineMeta;
        next_st.linePrev = st.lineSync;
        // A set in the same cycle as its clear wins, so no event is lost
        next_st.status = (st.status & ~clearMask) | eventSet;
        // Stall answer for requests whose decoding is switched off
        next_st.stall = (classReqSeen & ~classDecode)
            | (vendorReqSeen & ~vendorDecode);
        // Received control-out words; software cannot write them
        if (ctrlOutLoad) begin
            next_st.outWord[ctrlOutIndex] = ctrlOutData;
        end
        // Register writes
        if (regWr) begin
            case (regAddr)
                ued_pkg::ADDR_CONTROL: begin
                    next_st.decode = {regWrData[ued_pkg::CLASS_DECODE_BIT],
                        regWrData[ued_pkg::VENDOR_DECODE_BIT]};
                end
                ued_pkg::ADDR_EVENT_ENABLE: begin
                    next_st.enable = regWrData[15:0];
                end
                ued_pkg::ADDR_IFACE_STRING: begin
                    next_st.ifStr = regWrData[9:0];
                end
                ued_pkg::ADDR_CTRL_IN_WORD0: begin
                    next_st.inWord0 = regWrData;
                end
                default: begin
                    next_st.ifStr = st.ifStr;
                end
            endcase
        end
        // Read data stands only in the cycle after the strobe
        next_st.rdData = 32'h00000000;
        if (regRd) begin
            case (regAddr)
                ued_pkg::ADDR_CONTROL: begin
                    next_st.rdData[ued_pkg::CLASS_DECODE_BIT] = st.decode[1];
                    next_st.rdData[ued_pkg::VENDOR_DECODE_BIT] = st.decode[0];
                end
                ued_pkg::ADDR_EVENT_ENABLE: next_st.rdData = {16'h0000, st.enable};
                ued_pkg::ADDR_EVENT_STATUS: next_st.rdData = {16'h0000, st.status};
                ued_pkg::ADDR_IFACE_STRING: next_st.rdData = {22'h000000, st.ifStr};
                ued_pkg::ADDR_CTRL_OUT_WORD0: next_st.rdData = st.outWord[0];
                ued_pkg::ADDR_CTRL_OUT_WORD1: next_st.rdData = st.outWord[1];
                ued_pkg::ADDR_CTRL_OUT_WORD2: next_st.rdData = st.outWord[2];
                ued_pkg::ADDR_CTRL_OUT_WORD3: next_st.rdData = st.outWord[3];
                ued_pkg::ADDR_CTRL_IN_WORD0: next_st.rdData = st.inWord0;
                // Clear register and unmapped addresses read zero
                default: next_st.rdData = 32'h00000000;
            endcase
        end
        // Registered from next values so the request tracks status at once
        next_st.irq = |(next_st.status & next_st.enable);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    // Reset takes precedence over the clock enable
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st.status <= ued_pkg::EVENT_RESET;
            st.enable <= ued_pkg::EVENT_RESET;
            st.ifStr <= ued_pkg::IFSTR_RESET;
            st.outWord <= {4{ued_pkg::WORD_RESET}};
            st.inWord0 <= ued_pkg::WORD_RESET;
            st.decode <= ued_pkg::DECODE_RESET;
            st.lineMeta <= 2'h0;
            st.lineSync <= 2'h0;
            st.linePrev <= 2'h0;
            st.rdData <= ued_pkg::WORD_RESET;
            st.stall <= 1'b0;
            st.irq <= 1'b0;
        end else if (clkEn) begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign regRdData = st.rdData;
    assign ctrlInDataWord0 = st.inWord0;
    // Upper six bits are string descriptors, low four interfaces
    assign stringDescOn = st.ifStr[9:ued_pkg::STRING_LSB];
    assign interfaceOn = st.ifStr[ued_pkg::STRING_LSB-1:0];
    assign classDecodeOn = st.decode[1];
    assign vendorDecodeOn = st.decode[0];
    assign cvStall = st.stall;
    assign irq = st.irq;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------

    // Interrupt always equals the gated status
    property p_irqGate;
        @(posedge core_clk) disable iff (sys_rst)
        irq == |(st.status & st.enable);
    endproperty
    a_irqGate: assert property (p_irqGate)
        else $error("interrupt does not match enabled status");

    // Stopped-clock resume lands in bit 15
    property p_resumeStopped;
        @(posedge core_clk) disable iff (sys_rst)
        resumeStoppedSeen && clkEn |=> st.status[15];
    endproperty
    a_resumeStopped: assert property (p_resumeStopped)
        else $error("resume while stopped not recorded");

    // Reset end lands in bit 14
    property p_resetDone;
        @(posedge core_clk) disable iff (sys_rst)
        resetDoneSeen && clkEn |=> st.status[14];
    endproperty
    a_resetDone: assert property (p_resetDone)
        else $error("bus reset end not recorded");

    // Line change sets bit 12 one cycle later
    property p_lineTransition;
        @(posedge core_clk) disable iff (sys_rst)
        lineChanged && clkEn |=> st.status[12];
    endproperty
    a_lineTransition: assert property (p_lineTransition)
        else $error("bus transition not recorded");

    // Undecoded class request stalls and leaves bit 7 alone
    property p_classStall;
        @(posedge core_clk) disable iff (sys_rst)
        classReqSeen && !classDecode && clkEn
            |=> cvStall && (st.status[7] == $past(st.status[7] & ~clearMask[7]));
    endproperty
    a_classStall: assert property (p_classStall)
        else $error("undecoded class request not stalled");

    // Decoded vendor request flags bit 8 without stall
    property p_vendorFlag;
        @(posedge core_clk) disable iff (sys_rst)
        vendorReqSeen && vendorDecode && !classReqSeen && clkEn
            |=> st.status[8] && !cvStall;
    endproperty
    a_vendorFlag: assert property (p_vendorFlag)
        else $error("decoded vendor request mishandled");

    // Status is zero right after reset
    property p_statusReset;
        @(posedge core_clk)
        sys_rst |=> st.status == 16'h0000 && !irq;
    endproperty
    a_statusReset: assert property (p_statusReset)
        else $error("status not zero after reset");

    // Cleared bits go low unless an event arrived at once
    property p_clearOnes;
        @(posedge core_clk) disable iff (sys_rst)
        clkEn && clearMask != 16'h0000
            |=> (st.status & $past(clearMask) & ~$past(eventSet)) == 16'h0000;
    endproperty
    a_clearOnes: assert property (p_clearOnes)
        else $error("write-one clear failed");

    // Zeros in the clear pattern keep their bits
    property p_clearZerosKeep;
        @(posedge core_clk) disable iff (sys_rst)
        clkEn |=> (st.status & ~$past(clearMask))
            == (($past(st.status) | $past(eventSet)) & ~$past(clearMask));
    endproperty
    a_clearZerosKeep: assert property (p_clearZerosKeep)
        else $error("status changed without cause");

    // Enable register takes written data
    property p_enableWrite;
        @(posedge core_clk) disable iff (sys_rst)
        regWr && regAddr == ued_pkg::ADDR_EVENT_ENABLE && clkEn
            |=> st.enable == $past(regWrData[15:0]);
    endproperty
    a_enableWrite: assert property (p_enableWrite)
        else $error("enable register not written");

    // Control-out word loads from the engine
    property p_outWordLoad;
        @(posedge core_clk) disable iff (sys_rst)
        ctrlOutLoad && clkEn |=> st.outWord[$past(ctrlOutIndex)] == $past(ctrlOutData);
    endproperty
    a_outWordLoad: assert property (p_outWordLoad)
        else $error("control-out word not loaded");

    // Control-in word follows software write onto the engine output
    property p_inWordPath;
        @(posedge core_clk) disable iff (sys_rst)
        regWr && regAddr == ued_pkg::ADDR_CTRL_IN_WORD0 && clkEn
            |=> ctrlInDataWord0 == $past(regWrData);
    endproperty
    a_inWordPath: assert property (p_inWordPath)
        else $error("control-in word not presented");

    // Request held while no clear and no enable write
    property p_irqHold;
        @(posedge core_clk) disable iff (sys_rst)
        irq && clearMask == 16'h0000 && !(regWr && regAddr == ued_pkg::ADDR_EVENT_ENABLE)
            |=> irq;
    endproperty
    a_irqHold: assert property (p_irqHold)
        else $error("interrupt dropped while status set");

    // Status read returns sampled value in the cycle after the strobe
    property p_statusRead;
        @(posedge core_clk) disable iff (sys_rst)
        regRd && regAddr == ued_pkg::ADDR_EVENT_STATUS && clkEn
            |=> regRdData == {16'h0000, $past(st.status)};
    endproperty
    a_statusRead: assert property (p_statusRead)
        else $error("status read data wrong");

    // Configure and unconfigure both land in bit 13
    property p_configChange;
        @(posedge core_clk) disable iff (sys_rst)
        configChangeSeen && clkEn |=> st.status[13];
    endproperty
    a_configChange: assert property (p_configChange)
        else $error("configuration change not recorded");

    // Class/vendor phases land in bits 11..9
    property p_cvPhases;
        @(posedge core_clk) disable iff (sys_rst)
        clkEn |=> (st.status[11:9] & $past({cvStatusSeen, cvDataInSeen, cvDataOutSeen}))
            == $past({cvStatusSeen, cvDataInSeen, cvDataOutSeen});
    endproperty
    a_cvPhases: assert property (p_cvPhases)
        else $error("class or vendor phase not recorded");

    // Descriptor requests land in bits 6..4
    property p_getDescriptor;
        @(posedge core_clk) disable iff (sys_rst)
        clkEn |=> (st.status[6:4] & $past({getStringSeen, getConfigSeen, getDeviceSeen}))
            == $past({getStringSeen, getConfigSeen, getDeviceSeen});
    endproperty
    a_getDescriptor: assert property (p_getDescriptor)
        else $error("descriptor request not recorded");

    // Error, resume, suspend and reset land in bits 3..0
    property p_busEvents;
        @(posedge core_clk) disable iff (sys_rst)
        clkEn |=> (st.status[3:0] & $past({busErrorSeen, resumeSeen, suspendSeen, busResetSeen}))
            == $past({busErrorSeen, resumeSeen, suspendSeen, busResetSeen});
    endproperty
    a_busEvents: assert property (p_busEvents)
        else $error("bus event not recorded");

    // String and interface enables follow a write at once
    property p_ifaceStringWrite;
        @(posedge core_clk) disable iff (sys_rst)
        regWr && regAddr == ued_pkg::ADDR_IFACE_STRING && clkEn
            |=> {stringDescOn, interfaceOn} == $past(regWrData[9:0]);
    endproperty
    a_ifaceStringWrite: assert property (p_ifaceStringWrite)
        else $error("string or interface enables not written");

endmodule : ued_event_ctrl

`default_nettype wire

/* rtl/ued_pkg.sv */
/*
 * Constants for the device event and control-transfer register slice:
 * register byte addresses, event bit positions, field layouts and reset values.
 * Assumes a 32-bit word-addressed register port with byte addresses.
 */
// Contract
// - Enable bit per event gates its interrupt
// - Bit 15: resume seen while clock stopped
// - Bit 14: host bus reset has ended
// - Bit 13: configured or unconfigured change
// - Bit 12: any transition on bus lines
// - Bits 11,10,9: class/vendor status, in, out
// - Bit 8 vendor request, bit 7 class
// - Bits 6,5,4: string, config, device descriptor
// - Bits 3..0: error, resume, suspend, reset
// - Status read-only, resets to zero
// - Writing one clears status bit, zero keeps
// - String enables bits 9..4, one enables
// - Interface enables bits 3..0, one enables
// - Four read-only control-out words, reset zero
// - Control-in word zero read/write, feeds engine
// - Class/vendor events only when decode enabled; the code gates bits 8 and 7 only, bits 11..9 set regardless of decode
// - Enable register read/write at its address
package ued_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] ADDR_CONTROL = 32'hFFF06000;
    localparam logic [31:0] ADDR_EVENT_ENABLE = 32'hFFF06008;
    localparam logic [31:0] ADDR_EVENT_STATUS = 32'hFFF6000C;
    localparam logic [31:0] ADDR_EVENT_CLEAR = 32'hFFF60010;
    localparam logic [31:0] ADDR_IFACE_STRING = 32'hFFF06014;
    localparam logic [31:0] ADDR_CTRL_OUT_WORD0 = 32'hFFF06018;
    localparam logic [31:0] ADDR_CTRL_OUT_WORD1 = 32'hFFF0601C;
    localparam logic [31:0] ADDR_CTRL_OUT_WORD2 = 32'hFFF06020;
    localparam logic [31:0] ADDR_CTRL_OUT_WORD3 = 32'hFFF06024;
    localparam logic [31:0] ADDR_CTRL_IN_WORD0 = 32'hFFF06028;

    // ------------------------------------------------------------------
    // Event bit positions in status, enable and clear
    // ------------------------------------------------------------------
    localparam int EV_RESUME_STOPPED = 15;
    localparam int EV_RESET_DONE = 14;
    localparam int EV_CONFIG_CHANGE = 13;
    localparam int EV_BUS_TRANSITION = 12;
    localparam int EV_CV_STATUS = 11;
    localparam int EV_CV_DATA_IN = 10;
    localparam int EV_CV_DATA_OUT = 9;
    localparam int EV_VENDOR_REQ = 8;
    localparam int EV_CLASS_REQ = 7;
    localparam int EV_GET_STRING = 6;
    localparam int EV_GET_CONFIG = 5;
    localparam int EV_GET_DEVICE = 4;
    localparam int EV_BUS_ERROR = 3;
    localparam int EV_RESUME = 2;
    localparam int EV_SUSPEND = 1;
    localparam int EV_BUS_RESET = 0;

    // ------------------------------------------------------------------
    // Field layouts and reset values
    // ------------------------------------------------------------------
    localparam int EVENT_BITS = 16;
    localparam int STRING_LSB = 4;
    localparam int IFSTR_BITS = 10;
    localparam int CLASS_DECODE_BIT = 7;
    localparam int VENDOR_DECODE_BIT = 6;
    localparam logic [15:0] EVENT_RESET = 16'h0000;
    localparam logic [9:0] IFSTR_RESET = 10'h000;
    localparam logic [31:0] WORD_RESET = 32'h00000000;
    localparam logic [1:0] DECODE_RESET = 2'h0;

endpackage : ued_pkg

/* bench/ued_host_model.sv */
/*
 * Far-side model for the event slice: engine event pulses, bus line levels
 * and received control-out words, all driven off core_clk rising edges.
 * Assumes the bench calls its tasks by hierarchical name, one at a time.
 */
`timescale 1ns/100ps
`default_nettype none

module ued_host_model (
    input wire logic core_clk,
    output logic [15:0] evPulse,
    output logic busDp,
    output logic busDm,
    output logic ctrlOutLoad,
    output logic [1:0] ctrlOutIndex,
    output logic [31:0] ctrlOutData
);
    // Quiet engine and idle lines from time zero
    initial begin
        evPulse = 16'h0000;
        busDp = 1'b0;
        busDm = 1'b0;
        ctrlOutLoad = 1'b0;
        ctrlOutIndex = 2'h0;
        ctrlOutData = 32'h00000000;
    end

    // One-cycle event pulse on one status position
    task automatic fire(input int bitPos);
        @(posedge core_clk);
        evPulse <= 16'h0001 << bitPos;
        @(posedge core_clk);
        evPulse <= 16'h0000;
    endtask : fire

    // New line levels, held until the next call
    task automatic drive_lines(input logic dp, input logic dm);
        @(posedge core_clk);
        busDp <= dp;
        busDm <= dm;
    endtask : drive_lines

    // Data scrambled after the load so a late capture is caught
    task automatic load_word(input logic [1:0] idx, input logic [31:0] data);
        @(posedge core_clk);
        ctrlOutLoad <= 1'b1;
        ctrlOutIndex <= idx;
        ctrlOutData <= data;
        @(posedge core_clk);
        ctrlOutLoad <= 1'b0;
        ctrlOutIndex <= ~idx;
        ctrlOutData <= ~data;
    endtask : load_word
endmodule : ued_host_model

`default_nettype wire

/* bench/ued_event_ctrl_bench.sv */
/*
 * Self-checking bench for the event slice: register tasks, event loop,
 * masking, decode refusal, line transitions and control-out words.
 * Assumes the design and ued_host_model are compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none

module ued_event_ctrl_bench;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [31:0] regAddr = 32'h00000000;
    logic [31:0] regWrData = 32'h00000000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdData, ctrlInDataWord0, ctrlOutData;
    logic [15:0] evPulse;
    logic [5:0] stringDescOn;
    logic [3:0] interfaceOn;
    logic [1:0] ctrlOutIndex;
    logic busDp, busDm, ctrlOutLoad, classDecodeOn, vendorDecodeOn, cvStall, irq;
    int n_mismatch = 0;
    int checked = 0;
    int stallCount = 0;

    // -------------------------------------------------------------------
    // Clock, partner and design
    // -------------------------------------------------------------------
    always #2.5 core_clk = ~core_clk;

    // Counts stall cycles so a stretched pulse shows
    always @(posedge core_clk) if (cvStall === 1'b1) stallCount++;

    ued_host_model host (.core_clk(core_clk), .evPulse(evPulse), .busDp(busDp),
        .busDm(busDm), .ctrlOutLoad(ctrlOutLoad), .ctrlOutIndex(ctrlOutIndex),
        .ctrlOutData(ctrlOutData));

    ued_event_ctrl uut (.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(1'b1),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .busDp(busDp), .busDm(busDm),
        .resumeStoppedSeen(evPulse[15]), .resetDoneSeen(evPulse[14]),
        .configChangeSeen(evPulse[13]), .cvStatusSeen(evPulse[11]),
        .cvDataInSeen(evPulse[10]), .cvDataOutSeen(evPulse[9]),
        .vendorReqSeen(evPulse[8]), .classReqSeen(evPulse[7]),
        .getStringSeen(evPulse[6]), .getConfigSeen(evPulse[5]),
        .getDeviceSeen(evPulse[4]), .busErrorSeen(evPulse[3]),
        .resumeSeen(evPulse[2]), .suspendSeen(evPulse[1]), .busResetSeen(evPulse[0]),
        .ctrlOutLoad(ctrlOutLoad), .ctrlOutIndex(ctrlOutIndex), .ctrlOutData(ctrlOutData),
        .ctrlInDataWord0(ctrlInDataWord0), .stringDescOn(stringDescOn),
        .interfaceOn(interfaceOn), .classDecodeOn(classDecodeOn),
        .vendorDecodeOn(vendorDecodeOn), .cvStall(cvStall), .irq(irq));

    // -------------------------------------------------------------------
    // Access tasks
    // -------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        @(posedge core_clk);
        regAddr <= addr;
        regWrData <= data;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
        // Let the edge's updates settle before any check reads outputs
        #1;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
        @(posedge core_clk);
        regAddr <= addr;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        check(regRdData, exp);
    endtask : rd

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        n_mismatch++;
        wrap_up();
    end

    // -------------------------------------------------------------------
    // Tests
    // -------------------------------------------------------------------
    initial begin
        logic [31:0] m;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        // Reset values of every mapped register
        for (int a = 32'hFFF06000; a <= 32'hFFF06028; a += 4) rd(a, 32'h00000000);
        rd(ued_pkg::ADDR_EVENT_STATUS, 32'h00000000);
        check({irq, ctrlInDataWord0[30:0]}, 32'h00000000);
        wr(ued_pkg::ADDR_EVENT_ENABLE, 32'hFFFFFFFF);
        rd(ued_pkg::ADDR_EVENT_ENABLE, 32'h0000FFFF);
        wr(ued_pkg::ADDR_IFACE_STRING, 32'hFFFFFFFF);
        rd(ued_pkg::ADDR_IFACE_STRING, 32'h000003FF);
        wr(ued_pkg::ADDR_IFACE_STRING, 32'h000002A5);
        check({22'h0, stringDescOn, interfaceOn}, 32'h000002A5);
        wr(ued_pkg::ADDR_CTRL_IN_WORD0, 32'hA5C30F69);
        rd(ued_pkg::ADDR_CTRL_IN_WORD0, 32'hA5C30F69);
        check(ctrlInDataWord0, 32'hA5C30F69);
        // Read-only places refuse writes; an unmapped place reads zero
        wr(ued_pkg::ADDR_EVENT_STATUS, 32'h0000FFFF);
        rd(ued_pkg::ADDR_EVENT_STATUS, 32'h00000000);
        wr(ued_pkg::ADDR_CTRL_OUT_WORD1, 32'hFFFFFFFF);
        rd(ued_pkg::ADDR_CTRL_OUT_WORD1, 32'h00000000);
        rd(32'hFFF06100, 32'h00000000);
        // Every event but the bus transition alone: set, zero-clear keeps, one-clear drops
        wr(ued_pkg::ADDR_CONTROL, 32'h000000C0);
        check({30'h0, classDecodeOn, vendorDecodeOn}, 32'h00000003);
        rd(ued_pkg::ADDR_CONTROL, 32'h000000C0);
        for (int i = 0; i < 16; i++) begin
            if (i == ued_pkg::EV_BUS_TRANSITION) continue;
            m = 32'h00000001 << i;
            wr(ued_pkg::ADDR_EVENT_ENABLE, m);
            host.fire(i);
            rd(ued_pkg::ADDR_EVENT_STATUS, m);
            check({31'h0, irq}, 32'h00000001);
            wr(ued_pkg::ADDR_EVENT_CLEAR, ~m);
            rd(ued_pkg::ADDR_EVENT_STATUS, m);
            wr(ued_pkg::ADDR_EVENT_CLEAR, m);
            rd(ued_pkg::ADDR_EVENT_STATUS, 32'h00000000);
            check({31'h0, irq}, 32'h00000000);
        end
        // Masked event records but does not interrupt
        wr(ued_pkg::ADDR_EVENT_ENABLE, 32'h0000FFEF);
        host.fire(ued_pkg::EV_GET_DEVICE);
        rd(ued_pkg::ADDR_EVENT_STATUS, 32'h00000010);
        check({31'h0, irq}, 32'h00000000);
        wr(ued_pkg::ADDR_EVENT_ENABLE, 32'h00000010);
        repeat (2) @(posedge core_clk);
        check({31'h0, irq}, 32'h00000001);
        wr(ued_pkg::ADDR_EVENT_CLEAR, 32'h00000010);
        repeat (2) @(posedge core_clk);
        check({31'h0, irq}, 32'h00000000);
        // Decode off: requests refused with one stall each
        wr(ued_pkg::ADDR_CONTROL, 32'h00000000);
        check({30'h0, classDecodeOn, vendorDecodeOn}, 32'h00000000);
        stallCount = 0;
        host.fire(ued_pkg::EV_CLASS_REQ);
        host.fire(ued_pkg::EV_VENDOR_REQ);
        rd(ued_pkg::ADDR_EVENT_STATUS, 32'h00000000);
        check(stallCount, 32'h00000002);
        // Line changes flag a bus transition
        host.drive_lines(1'b1, 1'b0);
        repeat (8) @(posedge core_clk);
        rd(ued_pkg::ADDR_EVENT_STATUS, 32'h00001000);
        wr(ued_pkg::ADDR_EVENT_CLEAR, 32'h00001000);
        host.drive_lines(1'b0, 1'b1);
        repeat (8) @(posedge core_clk);
        rd(ued_pkg::ADDR_EVENT_STATUS, 32'h00001000);
        // Received words land at their own index
        for (int k = 0; k < 4; k++) host.load_word(k[1:0], 32'h5A3C9600 | k);
        for (int k = 0; k < 4; k++)
            rd(ued_pkg::ADDR_CTRL_OUT_WORD0 + 4 * k, 32'h5A3C9600 | k);
        // Mid-run reset; lines idle first so no transition follows it
        host.drive_lines(1'b0, 1'b0);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(ued_pkg::ADDR_EVENT_STATUS, 32'h00000000);
        rd(ued_pkg::ADDR_EVENT_ENABLE, 32'h00000000);
        rd(ued_pkg::ADDR_CTRL_OUT_WORD0, 32'h00000000);
        check({irq, ctrlInDataWord0[30:0]}, 32'h00000000);
        wrap_up();
    end
endmodule : ued_event_ctrl_bench

`default_nettype wire
